// ### rtl/qps_core_seq.sv
// Core sequencer: phases, fetch and execute pipeline, program counter and data addressing.
// Assumes an external execute unit on i_exec, program and data arrays outside, and an APB master.
`timescale 1ns/10ps

//Contract
// RL1 - Four non-overlapping phases from the input clock.
// RL2 - Program counter steps once per cycle in Q1.
// RL3 - Fetched word captured into the latch at Q4.
// RL4 - Fetch overlaps execute, one instruction per cycle.
// RL5 - Counter change flushes prefetched word, two cycles.
// RL6 - Latched instruction presented Q1, executed Q2-Q4.
// RL7 - Operand read in Q2, result written Q4.
// RL8 - Thirteen-bit program counter over 8K words.
// RL9 - Addresses wrap inside the implemented program size.
// RL10 - Reset starts at 0000h, interrupt vectors 0004h.
// RL11 - Four banks, lowest 32 locations special-function.
// RL12 - Two bank-select bits choose the direct bank.
// RL13 - General RAM ranges per bank and variant.
// RL14 - Top sixteen cells of each bank are shared.
// RL15 - General RAM reachable directly and through pointer.
// RL16 - Bank bits concatenated above seven-bit direct field.
// RL17 - Core registers at same offsets in every bank.
module qps_core_seq
  import qps_pkg::*;
#(
  parameter int unsigned PROG_WORDS = 4096,
  parameter bit FULL_BANK2 = 1'b1
)
(
  input wire logic i_mclk,
  input wire logic i_nrst,
  input wire logic i_psel,
  input wire logic i_penable,
  input wire logic i_pwrite,
  input wire logic [7:0] i_paddr,
  input wire logic [31:0] i_pwdata,
  output logic [31:0] o_prdata,
  output logic o_pready,
  output logic o_pslverr,
  output logic [PC_W-1:0] o_pmem_addr,
  input wire logic [INSTR_W-1:0] i_pmem_data,
  output logic [INSTR_W-1:0] o_instr,
  output logic o_instr_valid,
  output qps_phase_t o_phase,
  output logic [DATA_W-1:0] o_operand,
  input wire qps_exec_t i_exec,
  input wire logic i_int_req,
  output logic o_int_ack,
  output logic [PC_W-1:0] o_pc,
  output qps_dreq_t o_dreq,
  input wire logic [DATA_W-1:0] i_dmem_rdata
);

  // ----------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------
  localparam logic [PC_W-1:0] PC_MASK = PC_W'(PROG_WORDS - 1);

  qps_phase_t phase;
  logic [PC_W-1:0] pc_q;
  logic [PC_W-1:0] fetch_addr_q;
  logic [INSTR_W-1:0] instr_latch_q;
  logic instr_valid_q;
  logic flush_pend_q;
  logic [DATA_W-1:0] status_q;
  logic [DATA_W-1:0] pointer_q;
  logic [LATCH_W-1:0] program_counter_upper_latch_q;
  logic run_q;
  logic int_pend_q;
  logic int_ack_q;
  logic [DATA_W-1:0] operand_q;
  qps_dreq_t dreq_q;
  logic core_hit_q;
  logic [DIRECT_W-1:0] core_off_q;
  logic core_we_q;
  logic [DATA_W-1:0] core_wdata_q;
  logic [31:0] prdata_q;
  logic hit_q;
  logic at_q1;
  logic at_q2;
  logic at_q3;
  logic at_q4;
  logic [DADDR_W-1:0] op_addr;
  logic op_core;
  logic op_sfr;
  logic op_ram;
  logic [DADDR_W-1:0] op_cell;
  logic [DATA_W-1:0] core_rd;
  logic apb_setup;
  logic apb_wr;
  logic [5:0] apb_idx;
  logic apb_core;
  logic exec_pcl_wr;
  logic apb_pcl_wr;
  logic take_branch;
  logic take_int;
  logic [PC_W-1:0] jump_pc;

  // ----------------------------------------------------------------
  // Phase generator
  // ----------------------------------------------------------------
  qps_phase_gen u_phase
  (
    .i_mclk(i_mclk),
    .i_nrst(i_nrst),
    .i_run(run_q),
    .o_phase(phase)
  );

  // Edge qualifiers: each action fires on the clock edge that closes its phase.
  assign at_q1 = (phase == PH_Q1);
  assign at_q2 = (phase == PH_Q2);
  assign at_q3 = (phase == PH_Q3);
  assign at_q4 = (phase == PH_Q4);

  // ----------------------------------------------------------------
  // Operand address resolution
  // ----------------------------------------------------------------
  // The low seven bits select the cell in a bank; a zero field means go through the pointer.
  always_comb
  begin
    op_addr = {status_q[ST_BANK_HIGH], status_q[ST_BANK_LOW], instr_latch_q[DIRECT_W-1:0]}; // [RL12] [RL16]
    if (instr_latch_q[DIRECT_W-1:0] == IDX_INDIRECT_PORT)
      op_addr = {status_q[ST_IND_BANK], pointer_q}; // [RL15] [RL17]
    op_core = 1'b0;
    op_sfr = 1'b0;
    op_ram = 1'b0;
    op_cell = op_addr;
    if (op_addr[DIRECT_W-1:0] <= SFR_TOP)
    begin
      // Core registers decode on the in-bank offset only, so every bank sees them. [RL17]
      case (op_addr[DIRECT_W-1:0])
        IDX_INDIRECT_PORT, IDX_PCL, IDX_STATUS, IDX_POINTER, IDX_PROGRAM_COUNTER_UPPER_LATCH: op_core = 1'b1; // [RL11] [RL17]
        default: op_sfr = 1'b1; // [RL11]
      endcase
    end
    else if (op_addr[DIRECT_W-1:0] >= COMMON_BASE)
    begin
      op_ram = 1'b1;
      op_cell = {BANK0, op_addr[DIRECT_W-1:0]}; // [RL14]
    end
    else
    begin
      // Bank 3 has no cells below the shared block; bank 2 depends on the variant. [RL13]
      case (op_addr[DADDR_W-1:DIRECT_W])
        BANK0, BANK1: op_ram = 1'b1; // [RL13]
        BANK2: op_ram = FULL_BANK2 || (op_addr[DIRECT_W-1:0] < BANK2_SPLIT); // [RL13]
        default: op_ram = 1'b0;
      endcase
    end
  end

  // Core register read view; the indirect port through itself reads zero.
  always_comb
  begin
    case (op_addr[DIRECT_W-1:0])
      IDX_PCL: core_rd = pc_q[DATA_W-1:0];
      IDX_STATUS: core_rd = status_q;
      IDX_POINTER: core_rd = pointer_q;
      IDX_PROGRAM_COUNTER_UPPER_LATCH: core_rd = {3'h0, program_counter_upper_latch_q};
      default: core_rd = BYTE_ZERO;
    endcase
  end

  // ----------------------------------------------------------------
  // Program counter and fetch
  // ----------------------------------------------------------------
  assign exec_pcl_wr = core_we_q && (core_off_q == IDX_PCL);
  assign take_branch = at_q4 && instr_valid_q && (i_exec.branch || exec_pcl_wr);
  assign take_int = at_q4 && int_pend_q && !take_branch;
  assign jump_pc = exec_pcl_wr ? ({program_counter_upper_latch_q, core_wdata_q} & PC_MASK) : (i_exec.target & PC_MASK);
  assign apb_pcl_wr = apb_wr && (apb_idx == 6'(IDX_PCL));

  // A software write of the counter low byte acts at once; any pending change wraps. [RL9]
  always_ff @(posedge i_mclk)
  begin
    if (!i_nrst)
      pc_q <= RESET_VECTOR; // [RL10]
    else if (apb_pcl_wr)
      pc_q <= {program_counter_upper_latch_q, i_pwdata[DATA_W-1:0]} & PC_MASK; // [RL9]
    else if (take_branch)
      pc_q <= jump_pc; // [RL5] [RL9]
    else if (take_int)
      pc_q <= INT_VECTOR; // [RL10]
    else if (at_q1)
      pc_q <= (pc_q + PC_ONE) & PC_MASK; // [RL2] [RL8] [RL9]
  end

  // The fetch address is taken at the same Q1 edge that steps the counter. [RL2] [RL4]
  always_ff @(posedge i_mclk)
  begin
    if (!i_nrst)
      fetch_addr_q <= RESET_VECTOR;
    else if (at_q1)
      fetch_addr_q <= pc_q; // [RL2]
  end

  // The fetched word lands at Q4 and is then held through the whole next cycle. [RL3] [RL6]
  always_ff @(posedge i_mclk)
  begin
    if (!i_nrst)
    begin
      instr_latch_q <= {INSTR_W{1'b0}};
      instr_valid_q <= 1'b0;
    end
    else if (at_q4)
    begin
      instr_latch_q <= i_pmem_data; // [RL3] [RL4]
      instr_valid_q <= !(take_branch || take_int || flush_pend_q || apb_pcl_wr); // [RL5]
    end
  end

  // A software counter write between Q4 edges kills the word fetched from the old address.
  always_ff @(posedge i_mclk)
  begin
    if (!i_nrst)
      flush_pend_q <= 1'b0;
    else if (apb_pcl_wr)
      flush_pend_q <= 1'b1; // [RL5]
    else if (at_q4)
      flush_pend_q <= 1'b0;
  end

  // ----------------------------------------------------------------
  // Interrupt entry
  // ----------------------------------------------------------------
  // A request arriving as the pending flag is taken stays pending, set wins over clear.
  always_ff @(posedge i_mclk)
  begin
    if (!i_nrst)
      int_pend_q <= 1'b0;
    else if (i_int_req || (apb_wr && (apb_idx == IDX_CTRL) && i_pwdata[CTRL_INT]))
      int_pend_q <= 1'b1;
    else if (take_int)
      int_pend_q <= 1'b0; // [RL10]
  end

  always_ff @(posedge i_mclk)
  begin
    if (!i_nrst)
      int_ack_q <= 1'b0;
    else
      int_ack_q <= take_int;
  end

  // ----------------------------------------------------------------
  // Data memory operand read and destination write
  // ----------------------------------------------------------------
  // Request bits are registered at the edge before their phase, so rd shows in Q2 and we in Q4. [RL7]
  always_ff @(posedge i_mclk)
  begin
    if (!i_nrst)
    begin
      dreq_q <= '0;
      core_hit_q <= 1'b0;
      core_off_q <= IDX_INDIRECT_PORT;
      core_we_q <= 1'b0;
      core_wdata_q <= BYTE_ZERO;
    end
    else if (at_q1)
    begin
      dreq_q.rd <= instr_valid_q && (op_ram || op_sfr); // [RL6] [RL7]
      dreq_q.we <= 1'b0;
      dreq_q.special_function_cell <= op_sfr;
      dreq_q.addr <= op_cell; // [RL14] [RL15]
      core_hit_q <= op_core;
      core_off_q <= op_addr[DIRECT_W-1:0];
    end
    else if (at_q2)
      dreq_q.rd <= 1'b0;
    else if (at_q3)
    begin
      dreq_q.we <= instr_valid_q && i_exec.dest_we && (dreq_q.special_function_cell || op_ram); // [RL7]
      dreq_q.wdata <= i_exec.result;
      core_we_q <= instr_valid_q && i_exec.dest_we && core_hit_q;
      core_wdata_q <= i_exec.result;
    end
    else if (at_q4)
    begin
      dreq_q.we <= 1'b0;
      core_we_q <= 1'b0;
    end
  end

  // The operand is captured at the end of Q2 from the array or the core registers. [RL7]
  always_ff @(posedge i_mclk)
  begin
    if (!i_nrst)
      operand_q <= BYTE_ZERO;
    else if (at_q2)
      operand_q <= core_hit_q ? core_rd : (dreq_q.rd ? i_dmem_rdata : BYTE_ZERO); // [RL7]
  end

  // ----------------------------------------------------------------
  // Core registers
  // ----------------------------------------------------------------
  // Software writes win over a same-edge destination write; timeout and power-down bits are read only.
  always_ff @(posedge i_mclk)
  begin
    if (!i_nrst)
    begin
      status_q <= STATUS_RESET;
      pointer_q <= BYTE_ZERO;
      program_counter_upper_latch_q <= {LATCH_W{1'b0}};
    end
    else if (apb_wr && apb_core)
    begin
      case (apb_idx[DIRECT_W-2:0])
        IDX_STATUS[DIRECT_W-2:0]: status_q <= (i_pwdata[DATA_W-1:0] & STATUS_WMASK) | (status_q & ~STATUS_WMASK);
        IDX_POINTER[DIRECT_W-2:0]: pointer_q <= i_pwdata[DATA_W-1:0];
        IDX_PROGRAM_COUNTER_UPPER_LATCH[DIRECT_W-2:0]: program_counter_upper_latch_q <= i_pwdata[LATCH_W-1:0];
        default: program_counter_upper_latch_q <= program_counter_upper_latch_q;
      endcase
    end
    else if (at_q4 && core_we_q)
    begin
      case (core_off_q)
        IDX_STATUS: status_q <= (core_wdata_q & STATUS_WMASK) | (status_q & ~STATUS_WMASK); // [RL12]
        IDX_POINTER: pointer_q <= core_wdata_q; // [RL15]
        IDX_PROGRAM_COUNTER_UPPER_LATCH: program_counter_upper_latch_q <= core_wdata_q[LATCH_W-1:0]; // [RL17]
        default: program_counter_upper_latch_q <= program_counter_upper_latch_q;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // APB slave
  // ----------------------------------------------------------------
  assign apb_idx = i_paddr[APB_IDX_LSB+5:APB_IDX_LSB];
  assign apb_setup = i_psel && !i_penable;
  assign apb_wr = i_psel && i_penable && i_pwrite && hit_q;
  assign apb_core = (apb_idx == 6'(IDX_STATUS)) || (apb_idx == 6'(IDX_POINTER)) || (apb_idx == 6'(IDX_PROGRAM_COUNTER_UPPER_LATCH));

  always_ff @(posedge i_mclk)
  begin
    if (!i_nrst)
      run_q <= 1'b1;
    else if (apb_wr && (apb_idx == IDX_CTRL))
      run_q <= i_pwdata[CTRL_RUN];
  end

  // Read data and the decode result are fixed in the setup cycle, so the access phase needs no wait.
  always_ff @(posedge i_mclk)
  begin
    if (!i_nrst)
    begin
      prdata_q <= 32'h0000_0000;
      hit_q <= 1'b0;
    end
    else if (apb_setup)
    begin
      hit_q <= 1'b1;
      prdata_q <= 32'h0000_0000;
      case (apb_idx)
        6'(IDX_INDIRECT_PORT): prdata_q <= 32'h0000_0000;
        6'(IDX_PCL): prdata_q[DATA_W-1:0] <= pc_q[DATA_W-1:0];
        6'(IDX_STATUS): prdata_q[DATA_W-1:0] <= status_q;
        6'(IDX_POINTER): prdata_q[DATA_W-1:0] <= pointer_q;
        6'(IDX_PROGRAM_COUNTER_UPPER_LATCH): prdata_q[LATCH_W-1:0] <= program_counter_upper_latch_q;
        IDX_CTRL: prdata_q[1:0] <= {int_pend_q, run_q};
        IDX_STATE: prdata_q <= {11'h000, instr_valid_q, 5'(phase), 2'h0, pc_q};
        default: hit_q <= 1'b0;
      endcase
      if (i_paddr[APB_IDX_LSB-1:0] != 2'h0)
        hit_q <= 1'b0;
    end
  end

  assign o_prdata = prdata_q;
  assign o_pready = 1'b1;
  assign o_pslverr = i_psel && i_penable && !hit_q;

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign o_pmem_addr = fetch_addr_q;
  assign o_instr = instr_latch_q;
  assign o_instr_valid = instr_valid_q;
  assign o_phase = phase;
  assign o_operand = operand_q;
  assign o_int_ack = int_ack_q;
  assign o_pc = pc_q;
  assign o_dreq = dreq_q;

endmodule

// ### rtl/qps_phase_gen.sv
// Quadrature phase generator: walks Q1 to Q4 once per four input clocks.
// Assumes a synchronous active-low reset and a run level from the core.
`timescale 1ns/10ps

module qps_phase_gen
  import qps_pkg::*;
(
  input wire logic i_mclk,
  input wire logic i_nrst,
  input wire logic i_run,
  output qps_phase_t o_phase
);

  // ----------------------------------------------------------------
  // Phase state
  // ----------------------------------------------------------------
  qps_phase_t phase_q;
  qps_phase_t phase_d;

  // Only one phase is ever active, so the four phases never overlap; a halt parks after Q4.
  always_comb
  begin
    case (phase_q)
      PH_IDLE: phase_d = i_run ? PH_Q1 : PH_IDLE;
      PH_Q1: phase_d = PH_Q2;
      PH_Q2: phase_d = PH_Q3;
      PH_Q3: phase_d = PH_Q4;
      PH_Q4: phase_d = i_run ? PH_Q1 : PH_IDLE;
      default: phase_d = PH_IDLE;
    endcase
  end

  // The divide by four comes from stepping one phase per input clock. [RL1]
  always_ff @(posedge i_mclk)
  begin
    if (!i_nrst)
      phase_q <= PH_IDLE;
    else
      phase_q <= phase_d; // [RL1]
  end

  assign o_phase = phase_q;

endmodule

// ### rtl/qps_pkg.sv
// Shared constants, types and the register map of the quad phase core sequencer.
// Assumes one clock domain and software access over an APB slave with 32-bit data.
package qps_pkg;

  // ----------------------------------------------------------------
  // Widths and vectors
  // ----------------------------------------------------------------
  localparam int unsigned PC_W = 13;
  localparam int unsigned INSTR_W = 14;
  localparam int unsigned DATA_W = 8;
  localparam int unsigned DADDR_W = 9;
  localparam int unsigned DIRECT_W = 7;
  localparam int unsigned LATCH_W = 5;
  localparam logic [PC_W-1:0] RESET_VECTOR = 13'h0000;
  localparam logic [PC_W-1:0] INT_VECTOR = 13'h0004;
  localparam logic [PC_W-1:0] PC_ONE = 13'h0001;

  // ----------------------------------------------------------------
  // Register indices; the byte address is four times the index
  // ----------------------------------------------------------------
  localparam logic [DIRECT_W-1:0] IDX_INDIRECT_PORT = 7'h00;
  localparam logic [DIRECT_W-1:0] IDX_PCL = 7'h02;
  localparam logic [DIRECT_W-1:0] IDX_STATUS = 7'h03;
  localparam logic [DIRECT_W-1:0] IDX_POINTER = 7'h04;
  localparam logic [DIRECT_W-1:0] IDX_PROGRAM_COUNTER_UPPER_LATCH = 7'h0A;
  localparam logic [5:0] IDX_CTRL = 6'h10;
  localparam logic [5:0] IDX_STATE = 6'h11;
  localparam int unsigned APB_IDX_LSB = 2;

  // ----------------------------------------------------------------
  // Data memory layout inside one bank
  // ----------------------------------------------------------------
  localparam logic [DIRECT_W-1:0] SFR_TOP = 7'h1F;
  localparam logic [DIRECT_W-1:0] COMMON_BASE = 7'h70;
  localparam logic [DIRECT_W-1:0] BANK2_SPLIT = 7'h50;
  localparam logic [1:0] BANK0 = 2'h0;
  localparam logic [1:0] BANK1 = 2'h1;
  localparam logic [1:0] BANK2 = 2'h2;
  localparam logic [1:0] BANK3 = 2'h3;

  // ----------------------------------------------------------------
  // Status field layout and reset values
  // ----------------------------------------------------------------
  localparam int unsigned ST_IND_BANK = 7;
  localparam int unsigned ST_BANK_HIGH = 6;
  localparam int unsigned ST_BANK_LOW = 5;
  localparam logic [DATA_W-1:0] STATUS_RESET = 8'h18;
  localparam logic [DATA_W-1:0] STATUS_WMASK = 8'hE7;
  localparam logic [DATA_W-1:0] BYTE_ZERO = 8'h00;
  localparam int unsigned CTRL_RUN = 0;
  localparam int unsigned CTRL_INT = 1;

  // ----------------------------------------------------------------
  // Phase sequence and carriers
  // ----------------------------------------------------------------
  typedef enum logic [4:0] {
    PH_IDLE = 5'b00001,
    PH_Q1 = 5'b00010,
    PH_Q2 = 5'b00100,
    PH_Q3 = 5'b01000,
    PH_Q4 = 5'b10000
  } qps_phase_t;

  typedef struct packed {
    logic rd;
    logic we;
    logic special_function_cell;
    logic [DADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
  } qps_dreq_t;

  typedef struct packed {
    logic dest_we;
    logic [DATA_W-1:0] result;
    logic branch;
    logic [PC_W-1:0] target;
  } qps_exec_t;

endpackage

// ### sim/qps_core_seq_assertions.sv
// Port checks for the core sequencer.
// Assumes the run bit stays set; bound in below.
`timescale 1ns/10ps
module qps_core_seq_chk
  import qps_pkg::*;
#(
  parameter int unsigned PROG_WORDS = 4096
)
(
  input wire logic i_mclk,
  input wire logic i_nrst,
  input wire logic [PC_W-1:0] o_pmem_addr,
  input wire logic [INSTR_W-1:0] i_pmem_data,
  input wire logic [INSTR_W-1:0] o_instr,
  input wire logic o_instr_valid,
  input wire qps_phase_t o_phase,
  input wire logic [DATA_W-1:0] o_operand,
  input wire qps_exec_t i_exec,
  input wire logic o_int_ack,
  input wire logic [PC_W-1:0] o_pc,
  input wire qps_dreq_t o_dreq,
  input wire logic [DATA_W-1:0] i_dmem_rdata
);
  // ----
  // Shared clocking
  // ----
  // Wrap mask of the implemented program size.
  localparam logic [PC_W-1:0] MASK = PC_W'(PROG_WORDS - 1);
  default clocking cb @(posedge i_mclk);
  endclocking
  default disable iff (!i_nrst);
  chk_phase_onehot: assert property ($onehot(o_phase))
    else $error("phase not one-hot");
  chk_phase_walk: assert property (o_phase == PH_Q1 |=> o_phase == PH_Q2 ##1 o_phase == PH_Q3 ##1 o_phase == PH_Q4)
    else $error("phase order broken");
  chk_pc_step: assert property (o_phase == PH_Q1 |=> o_pc == (($past(o_pc) + PC_ONE) & MASK) && o_pmem_addr == $past(o_pc))
    else $error("counter step wrong");
  chk_fetch_hold: assert property (o_phase != PH_Q1 |=> $stable(o_pmem_addr))
    else $error("fetch address moved");
  chk_latch_q4: assert property (o_phase == PH_Q4 |=> o_instr == $past(i_pmem_data))
    else $error("word not latched");
  chk_instr_stands: assert property (o_phase != PH_Q4 |=> $stable(o_instr))
    else $error("latch changed early");
  chk_rd_phase: assert property (o_dreq.rd |-> o_phase == PH_Q2)
    else $error("read outside Q2");
  chk_we_phase: assert property (o_dreq.we |-> o_phase == PH_Q4)
    else $error("write outside Q4");
  chk_operand_take: assert property (o_phase == PH_Q2 && o_dreq.rd |=> o_operand == $past(i_dmem_rdata))
    else $error("operand not captured");
  chk_branch_flush: assert property (o_phase == PH_Q4 && o_instr_valid && i_exec.branch |=>
    (o_pc == ($past(i_exec.target) & MASK) && !o_instr_valid) ##1 !o_instr_valid [*3] ##1 o_instr_valid)
    else $error("branch flush wrong");
  chk_int_vector: assert property (o_int_ack |-> o_pc == INT_VECTOR && !o_instr_valid && o_phase == PH_Q1)
    else $error("interrupt vector wrong");
  chk_shared_map: assert property (o_dreq.rd && o_dreq.addr[6:4] == 3'h7 |-> o_dreq.addr[8:7] == 2'h0)
    else $error("shared cell not folded");
  chk_sfr_low: assert property (o_dreq.rd && o_dreq.special_function_cell |-> o_dreq.addr[6:5] == 2'h0)
    else $error("special cell above 1Fh");
endmodule

bind qps_core_seq qps_core_seq_chk #(.PROG_WORDS(PROG_WORDS)) chk_u (.i_mclk(i_mclk), .i_nrst(i_nrst),
  .o_pmem_addr(o_pmem_addr), .i_pmem_data(i_pmem_data), .o_instr(o_instr), .o_instr_valid(o_instr_valid),
  .o_phase(o_phase), .o_operand(o_operand), .i_exec(i_exec), .o_int_ack(o_int_ack), .o_pc(o_pc),
  .o_dreq(o_dreq), .i_dmem_rdata(i_dmem_rdata));

// ### sim/qps_core_seq_tb.sv
// Self-checking bench for the core sequencer.
// Assumes the bound checker and the smallest program variant.
`timescale 1ns/10ps
module qps_core_seq_tb
  import qps_pkg::*;
;
  localparam int unsigned PW = 1024;
  logic i_mclk = 1'b0;
  logic i_nrst = 1'b0;
  logic psel = 1'b0;
  logic pen = 1'b0;
  logic pwr = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic [PC_W-1:0] pmem_addr;
  logic [INSTR_W-1:0] pmem_data;
  logic [INSTR_W-1:0] instr;
  logic instr_valid;
  qps_phase_t phase;
  logic [DATA_W-1:0] operand;
  qps_exec_t exec_s = '0;
  logic int_req = 1'b0;
  logic int_ack;
  logic [PC_W-1:0] pc;
  qps_dreq_t dreq;
  logic [DATA_W-1:0] dmem_rdata;
  logic [DATA_W-1:0] shadow [0:511];
  int fails = 0;
  int comparisons = 0;
  int cycles = 0;
  // ----
  // Clock, design and arrays
  // ----
  // Half period of the 125 MHz clock.
  always #4 i_mclk = ~i_mclk;
  qps_core_seq #(.PROG_WORDS(PW), .FULL_BANK2(1'b0)) dut_u (.i_mclk(i_mclk), .i_nrst(i_nrst), .i_psel(psel),
    .i_penable(pen), .i_pwrite(pwr), .i_paddr(paddr), .i_pwdata(pwdata), .o_prdata(prdata), .o_pready(pready),
    .o_pslverr(pslverr), .o_pmem_addr(pmem_addr), .i_pmem_data(pmem_data), .o_instr(instr),
    .o_instr_valid(instr_valid), .o_phase(phase), .o_operand(operand), .i_exec(exec_s), .i_int_req(int_req),
    .o_int_ack(int_ack), .o_pc(pc), .o_dreq(dreq), .i_dmem_rdata(dmem_rdata));
  qps_mem_model mem_u (.i_mclk(i_mclk), .i_pmem_addr(pmem_addr), .o_pmem_data(pmem_data), .i_dreq(dreq),
    .o_dmem_rdata(dmem_rdata));
  task automatic print_verdict();
    $display("comparisons %0d fails %0d", comparisons, fails);
    if (fails == 0 && comparisons > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  // A hang counts as a mismatch and ends the run.
  always @(posedge i_mclk)
  begin
    cycles++;
    if (cycles == 5000)
    begin
      fails++;
      print_verdict();
    end
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    comparisons++;
    if (got !== exp)
    begin
      fails++;
      $display("[FAIL] %0t %s: got %h expected %h", $time, what, got, exp);
    end
  endtask
  function automatic logic [7:0] ba(input logic [6:0] idx);
    return {idx[5:0], 2'b00};
  endfunction
  // One transfer; the request stands until pready is seen high.
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd, output logic [31:0] rd,
    output logic err);
    @(posedge i_mclk);
    psel <= 1'b1;
    pen <= 1'b0;
    pwr <= wr;
    paddr <= a;
    pwdata <= wd;
    @(posedge i_mclk);
    pen <= 1'b1;
    do
      @(posedge i_mclk);
    while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    pen <= 1'b0;
  endtask
  task automatic wreg(input logic [7:0] a, input logic [31:0] wd);
    logic [31:0] rd;
    logic err;
    apb(1'b1, a, wd, rd, err);
  endtask
  task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp, input logic xerr, input string what);
    logic [31:0] rd;
    logic err;
    apb(1'b0, a, 32'h0, rd, err);
    chk(err, xerr, what);
    chk(rd, exp, what);
  endtask
  // ----
  // Scenarios
  // ----
  task automatic t_boot();
    @(negedge i_mclk);
    chk(phase, PH_IDLE, "idle");
    @(negedge i_mclk);
    chk(phase, PH_Q1, "first phase");
    @(negedge i_mclk);
    chk(pmem_addr, RESET_VECTOR, "first fetch");
    chk(pc, PC_ONE, "counter step");
    repeat (3) @(negedge i_mclk);
    chk(instr, 14'h0000, "first word");
    chk(instr_valid, 1'h1, "first valid");
    $display("test boot done");
  endtask
  task automatic t_regs();
    rd_chk(ba(IDX_STATUS), 32'h18, 1'h0, "status reset");
    rd_chk(ba(IDX_CTRL), 32'h1, 1'h0, "ctrl reset");
    rd_chk(ba(IDX_POINTER), 32'h0, 1'h0, "pointer reset");
    rd_chk(ba(IDX_INDIRECT_PORT), 32'h0, 1'h0, "port reads 0");
    wreg(ba(IDX_PROGRAM_COUNTER_UPPER_LATCH), 32'hFF);
    rd_chk(ba(IDX_PROGRAM_COUNTER_UPPER_LATCH), 32'h1F, 1'h0, "latch width");
    wreg(ba(IDX_STATUS), 32'h0);
    rd_chk(ba(IDX_STATUS), 32'h18, 1'h0, "status read-only");
    rd_chk(8'h80, 32'h0, 1'h1, "unmapped");
    rd_chk(8'h0D, {24'h0, STATUS_RESET}, 1'h1, "misaligned");
    $display("test regs done");
  endtask
  // Branch to tgt, then judge the fetch, the operand read and a result write.
  task automatic t_exec(input logic [7:0] st, input logic [7:0] ptr, input logic [12:0] tgt, input logic hit,
    input logic special_function_cell, input logic [8:0] da, input logic [7:0] op0);
    logic [12:0] fa;
    logic [7:0] res;
    fa = tgt & 13'(PW - 1);
    res = 8'hC0 ^ tgt[7:0];
    wreg(ba(IDX_STATUS), {24'h0, st});
    wreg(ba(IDX_POINTER), {24'h0, ptr});
    do
      @(negedge i_mclk);
    while (phase !== PH_Q3 || instr_valid !== 1'b1);
    @(posedge i_mclk);
    exec_s.branch <= 1'b1;
    exec_s.target <= tgt;
    @(posedge i_mclk);
    exec_s.branch <= 1'b0;
    @(negedge i_mclk);
    chk(instr_valid, 1'h0, "flushed slot");
    @(negedge i_mclk);
    chk(pmem_addr, fa, "target fetch");
    repeat (4) @(negedge i_mclk);
    chk(instr, {1'b0, fa}, "target word");
    chk(dreq.rd, hit, "operand read");
    if (hit)
    begin
      chk(dreq.addr, da, "data address");
      chk(dreq.special_function_cell, special_function_cell, "special cell");
    end
    @(posedge i_mclk);
    exec_s.dest_we <= hit;
    exec_s.result <= res;
    @(negedge i_mclk);
    chk(operand, hit ? shadow[da] : op0, "operand");
    @(posedge i_mclk);
    exec_s.dest_we <= 1'b0;
    @(negedge i_mclk);
    chk(dreq.we, hit, "result write");
    if (hit)
    begin
      chk(dreq.wdata, res, "result data");
      shadow[da] = res;
    end
    $display("test exec %h done", tgt);
  endtask
  task automatic t_irq();
    int n;
    @(posedge i_mclk);
    int_req <= 1'b1;
    @(posedge i_mclk);
    int_req <= 1'b0;
    for (n = 0; n < 16 && int_ack !== 1'b1; n++)
      @(negedge i_mclk);
    chk(int_ack, 1'h1, "interrupt taken");
    chk(pc, INT_VECTOR, "vector");
    @(negedge i_mclk);
    chk(pmem_addr, INT_VECTOR, "vector fetch");
    rd_chk(ba(IDX_CTRL), 32'h1, 1'h0, "pending cleared");
    $display("test irq done");
  endtask
  // Main sequence: reset for six cycles, then each scenario in turn.
  initial
  begin
    for (int i = 0; i < 512; i++)
      shadow[i] = 8'(i) ^ 8'h5A;
    repeat (6) @(posedge i_mclk);
    i_nrst <= 1'b1;
    t_boot();
    t_regs();
    t_exec(8'h00, 8'h00, 13'h1C25, 1'h1, 1'h0, 9'h025, 8'h00);
    t_exec(8'h20, 8'h00, 13'h0025, 1'h1, 1'h0, 9'h0A5, 8'h00);
    t_exec(8'h40, 8'h00, 13'h0045, 1'h1, 1'h0, 9'h145, 8'h00);
    t_exec(8'h40, 8'h00, 13'h0055, 1'h0, 1'h0, 9'h000, 8'h00);
    t_exec(8'h60, 8'h00, 13'h0025, 1'h0, 1'h0, 9'h000, 8'h00);
    t_exec(8'h60, 8'h00, 13'h007A, 1'h1, 1'h0, 9'h07A, 8'h00);
    t_exec(8'h20, 8'h00, 13'h007A, 1'h1, 1'h0, 9'h07A, 8'h00);
    t_exec(8'h40, 8'h00, 13'h0005, 1'h1, 1'h1, 9'h105, 8'h00);
    t_exec(8'h40, 8'h00, 13'h0003, 1'h0, 1'h0, 9'h000, 8'h58);
    t_exec(8'h60, 8'hA5, 13'h0080, 1'h1, 1'h0, 9'h0A5, 8'h00);
    t_exec(8'h80, 8'h73, 13'h0100, 1'h1, 1'h0, 9'h073, 8'h00);
    t_irq();
    print_verdict();
  end
endmodule

// ### sim/qps_mem_model.sv
// Program and data arrays beside the core sequencer.
// Assumes the request carrier of the package.
`timescale 1ns/10ps
module qps_mem_model
  import qps_pkg::*;
(
  input wire logic i_mclk,
  input wire logic [PC_W-1:0] i_pmem_addr,
  output logic [INSTR_W-1:0] o_pmem_data,
  input wire qps_dreq_t i_dreq,
  output logic [DATA_W-1:0] o_dmem_rdata
);
  logic [DATA_W-1:0] ram_q [0:511];
  logic [DATA_W-1:0] last_q = 8'h00;
  // Each word echoes its address, so any fetch is recognisable.
  assign o_pmem_data = {1'b0, i_pmem_addr};
  // Cells start from a pattern the bench knows.
  initial
  begin
    for (int i = 0; i < 512; i++)
      ram_q[i] = 8'(i) ^ 8'h5A;
  end
  // Outside a read the bus shows the inverse of the last value, never a stale copy.
  assign o_dmem_rdata = i_dreq.rd ? ram_q[i_dreq.addr] : ~last_q;
  // Writes land at the edge; shared cells own one slot only.
  always @(posedge i_mclk)
  begin
    if (i_dreq.rd)
      last_q <= ram_q[i_dreq.addr];
    if (i_dreq.we)
      ram_q[i_dreq.addr] <= i_dreq.wdata;
  end
endmodule
